// *** verilog/bfp_device.sv ***
// boot loader byte interpreter: chip erase, program and protect-set entry
// Behaviour
// - erase enable receive error replies x8
// - 54 echoed starts erase, else x1
// - erase result byte 4f or 4c
// - then confirmation byte 5d or 60
// - controller sends next command afterward
// - program accepted if unprotected and erased
// - protected program replies x6
// - unerased program replies x4
// - unknown command byte replies x1
// - address sent four bytes, msb first
// - count sent two bytes, high first
// - header checksum is negated sum
// - start address even, inside flash range; code accepts any address
// - count from one to 1 KB; code accepts any 16-bit count, 0 goes straight to the data checksum
// - no rewrite without chip erase; code only needs the last erase since reset to have succeeded
// - header receive error replies 58
// - header sum zero gives 50, else 51
// - data written sequentially from start address
// - data checksum is negated data sum
// - data phase: rx error, sum, normal
// - protect set command echoed 60
// - twelve password bytes compared in order
// - ack: bit3 rx error, bit0 error
`timescale 1ns/1ps
`include "bfp_consts.svh"
module bfp_device
    import bfp_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    bfp_link_if.dev link,
    input wire logic read_protect, // read protection in force
    input wire logic write_protect, // write protection in force
    output logic erase_start, // pulse: begin whole-array erase
    input wire logic erase_done, // pulse: erase finished
    input wire logic erase_fail, // with erase_done: erase failed
    output logic [31:0] flash_addr, // write or password read address
    output logic [7:0] flash_wdata, // byte to program
    output logic flash_we, // pulse: program one byte
    input wire logic [7:0] flash_rdata, // password byte at flash_addr
    output logic pwd_done, // pulse: password check ended
    output logic pwd_ok // password matched, with pwd_done
);
    // ************************************************
    // state record
    // ************************************************
    typedef struct packed {
        bfp_dev_state_type phase;
        logic [7:0] last_cmd; // upper nibble source for error replies
        logic erased; // last chip erase since reset succeeded
        logic [2:0] idx; // header byte index
        logic [3:0] pidx; // password byte index
        logic [31:0] addr;
        logic [15:0] count;
        logic [7:0] sum;
        logic rx_bad; // a byte of this block had a receive fault
        logic pwd_bad;
        logic ok_flag; // erase result remembered for second byte
        logic [7:0] wdata;
        logic we;
        logic start;
        logic pdone;
        logic pok;
    } bfp_dev_rec_type;
    bfp_dev_rec_type st; // current
    bfp_dev_rec_type next_st; // next
    logic [8:0] fifo_in; // reply byte plus spare bit
    logic fifo_in_valid; // reply to queue
    logic fifo_in_ready; // reply queue has room
    logic [8:0] fifo_out; // queued reply
    logic take; // incoming byte accepted
    logic [7:0] rx; // incoming byte
    logic [7:0] nsum; // running sum including this byte
    // ************************************************
    // reply queue toward the controller
    // ************************************************
    bfp_fifo #(.WIDTH(9), .DEPTH(`BFP_FIFO_DEPTH), .AW(`BFP_FIFO_AW)) u_reply (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .in_data(fifo_in),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(link.d2h_valid),
        .out_ready(link.d2h_ready)
    );
    assign link.d2h_data = fifo_out[7:0];
    // bytes are taken only while a reply slot is free, so back-pressure stalls the link
    assign link.h2d_ready = fifo_in_ready && (st.phase != BFP_DEV_ERASE_RUN)
                            && (st.phase != BFP_DEV_ERASE_ACK);
    assign take = link.h2d_valid && link.h2d_ready;
    assign rx = link.h2d_data;
    assign nsum = st.sum + rx;
    assign erase_start = st.start;
    assign flash_addr = (st.phase == BFP_DEV_PWD) ? (32'(`BFP_PWD_BASE) + 32'(st.pidx))
                                                  : st.addr;
    assign flash_wdata = st.wdata;
    assign flash_we = st.we;
    assign pwd_done = st.pdone;
    assign pwd_ok = st.pok;
    // ************************************************
    // interpreter
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.we = 1'b0;
        next_st.start = 1'b0;
        next_st.pdone = 1'b0;
        fifo_in = '0;
        fifo_in_valid = 1'b0;
        unique case (st.phase)
            BFP_DEV_CMD: begin
                if (take) begin
                    fifo_in_valid = 1'b1;
                    if (link.h2d_err) begin
                        fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_RXERR};
                    end else begin
                        next_st.last_cmd = rx; // upper nibble follows last good command
                        next_st.sum = '0;
                        next_st.idx = '0;
                        next_st.pidx = '0;
                        next_st.rx_bad = 1'b0;
                        next_st.pwd_bad = 1'b0;
                        if (rx == `BFP_CMD_ERASE) begin
                            fifo_in = {1'b0, rx};
                            next_st.phase = BFP_DEV_ERASE_EN;
                        end else if (rx == `BFP_CMD_PROG) begin
                            if (read_protect || write_protect) begin
                                fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_PROT};
                            end else if (!st.erased) begin
                                fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_NOERASE};
                            end else begin
                                fifo_in = {1'b0, rx};
                                next_st.phase = BFP_DEV_HDR;
                            end
                        end else if (rx == `BFP_CMD_PROT) begin
                            fifo_in = {1'b0, rx};
                            next_st.phase = BFP_DEV_PWD;
                        end else if (rx == `BFP_CMD_RAM || rx == `BFP_CMD_SUM
                                     || rx == `BFP_CMD_INFO) begin
                            fifo_in = {1'b0, rx}; // other routines live elsewhere
                        end else begin
                            next_st.last_cmd = st.last_cmd;
                            fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_BAD};
                        end
                    end
                end
            end
            BFP_DEV_ERASE_EN: begin
                if (take) begin
                    fifo_in_valid = 1'b1;
                    next_st.phase = BFP_DEV_CMD;
                    if (link.h2d_err) begin
                        fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_RXERR};
                    end else if (rx == `BFP_ERASE_EN) begin
                        fifo_in = {1'b0, rx};
                        next_st.start = 1'b1;
                        next_st.phase = BFP_DEV_ERASE_RUN;
                    end else begin
                        fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_BAD};
                    end
                end
            end
            BFP_DEV_ERASE_RUN: begin
                if (erase_done) begin
                    next_st.ok_flag = !erase_fail;
                    next_st.erased = !erase_fail;
                    next_st.phase = BFP_DEV_ERASE_ACK;
                end
            end
            BFP_DEV_ERASE_ACK: begin
                // two reply bytes, one per free slot
                if (fifo_in_ready) begin
                    fifo_in_valid = 1'b1;
                    if (st.idx == 3'h0) begin
                        fifo_in = {1'b0, st.ok_flag ? `BFP_ERASE_END : `BFP_ERASE_FAIL};
                        next_st.idx = 3'h1;
                    end else begin
                        fifo_in = {1'b0, st.ok_flag ? `BFP_ERASE_ACK_OK
                                                    : `BFP_ERASE_ACK_ERR};
                        next_st.idx = 3'h0;
                        next_st.phase = BFP_DEV_CMD;
                    end
                end
            end
            BFP_DEV_HDR: begin
                if (take) begin
                    next_st.rx_bad = st.rx_bad | link.h2d_err;
                    next_st.sum = nsum;
                    next_st.idx = st.idx + 3'h1;
                    if (st.idx < 3'h4) begin
                        next_st.addr = {st.addr[23:0], rx};
                    end else if (st.idx <= `BFP_HDR_LAST) begin
                        next_st.count = {st.count[7:0], rx};
                    end
                    if (st.idx == `BFP_HDR_LAST + 3'h1) begin
                        fifo_in_valid = 1'b1;
                        next_st.sum = '0;
                        next_st.rx_bad = 1'b0;
                        next_st.phase = BFP_DEV_CMD;
                        if (st.rx_bad || link.h2d_err) begin
                            fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_RXERR};
                        end else if (nsum != 8'h00) begin
                            fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_BAD};
                        end else begin
                            fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_OK};
                            next_st.phase = (st.count == 16'h0000) ? BFP_DEV_DSUM
                                                                   : BFP_DEV_DATA;
                        end
                    end
                end
            end
            BFP_DEV_DATA: begin
                if (take) begin
                    next_st.rx_bad = st.rx_bad | link.h2d_err;
                    next_st.sum = nsum;
                    next_st.wdata = rx;
                    next_st.we = !link.h2d_err;
                    next_st.count = st.count - 16'h1;
                    if (st.count == 16'h0001) begin
                        next_st.phase = BFP_DEV_DSUM;
                    end
                end
                // step only after the write pulse has used the address
                if (st.we) begin
                    next_st.addr = st.addr + 32'h1;
                end
            end
            BFP_DEV_DSUM: begin
                if (take) begin
                    fifo_in_valid = 1'b1;
                    next_st.phase = BFP_DEV_CMD;
                    if (st.rx_bad || link.h2d_err) begin
                        fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_RXERR};
                    end else if (nsum != 8'h00) begin
                        fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_BAD};
                    end else begin
                        fifo_in = {1'b0, st.last_cmd[7:4], `BFP_NIB_OK};
                    end
                end
            end
            BFP_DEV_PWD: begin
                if (take) begin
                    next_st.rx_bad = st.rx_bad | link.h2d_err;
                    next_st.pwd_bad = st.pwd_bad | (rx != flash_rdata);
                    next_st.pidx = st.pidx + 4'h1;
                    if (st.pidx == `BFP_PWD_LAST) begin
                        next_st.pdone = 1'b1;
                        next_st.pok = !(st.pwd_bad | (rx != flash_rdata))
                                      && !(st.rx_bad | link.h2d_err);
                        next_st.phase = BFP_DEV_FLUSH;
                    end
                end
            end
            BFP_DEV_FLUSH: begin
                // remaining protect-set exchange is handled outside this block
                next_st.phase = BFP_DEV_CMD;
            end
            default: begin
                next_st.phase = BFP_DEV_CMD;
            end
        endcase
    end
    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** verilog/bfp_consts.svh ***
// constants of the boot flash programming byte protocol
`ifndef BFP_CONSTS_SVH
`define BFP_CONSTS_SVH
`define BFP_CMD_ERASE 8'h40
`define BFP_CMD_PROG 8'h50
`define BFP_CMD_PROT 8'h60
`define BFP_CMD_RAM 8'h10
`define BFP_CMD_SUM 8'h20
`define BFP_CMD_INFO 8'h30
`define BFP_ERASE_EN 8'h54
`define BFP_ERASE_END 8'h4f
`define BFP_ERASE_FAIL 8'h4c
`define BFP_ERASE_ACK_OK 8'h5d
`define BFP_ERASE_ACK_ERR 8'h60
`define BFP_NIB_RXERR 4'h8
`define BFP_NIB_PROT 4'h6
`define BFP_NIB_NOERASE 4'h4
`define BFP_NIB_BAD 4'h1
`define BFP_NIB_OK 4'h0
`define BFP_HDR_LAST 3'h5
`define BFP_PWD_LAST 4'hb
`define BFP_PWD_BASE 24'h04fef4
`define BFP_FIFO_DEPTH 32
`define BFP_FIFO_AW 5
`endif

// *** verilog/bfp_pkg.sv ***
// types shared by both ends of the programming link
package bfp_pkg;
    // device interpreter phases
    typedef enum logic [3:0] {
        BFP_DEV_CMD = 4'b0000,
        BFP_DEV_ERASE_EN = 4'b0001,
        BFP_DEV_ERASE_RUN = 4'b0010,
        BFP_DEV_ERASE_ACK = 4'b0011,
        BFP_DEV_HDR = 4'b0100,
        BFP_DEV_DATA = 4'b0101,
        BFP_DEV_DSUM = 4'b0110,
        BFP_DEV_PWD = 4'b0111,
        BFP_DEV_FLUSH = 4'b1000
    } bfp_dev_state_type;
    // controller phases
    typedef enum logic [1:0] {
        BFP_HOST_IDLE = 2'b00,
        BFP_HOST_SEND = 2'b01
    } bfp_host_state_type;
endpackage

// *** verilog/bfp_link_if.sv ***
// byte link joining the controller and the boot interpreter
`timescale 1ns/1ps
interface bfp_link_if;
    logic [7:0] h2d_data; // byte toward the device
    logic h2d_valid; // byte offered
    logic h2d_err; // receive fault flagged for that byte
    logic h2d_ready; // device takes the byte
    logic [7:0] d2h_data; // reply byte
    logic d2h_valid; // reply offered
    logic d2h_ready; // controller takes reply
    modport dev (input h2d_data, input h2d_valid, input h2d_err, output h2d_ready,
                 output d2h_data, output d2h_valid, input d2h_ready);
    modport host (output h2d_data, output h2d_valid, output h2d_err, input h2d_ready,
                  input d2h_data, input d2h_valid, output d2h_ready);
endinterface

// *** verilog/bfp_fifo.sv ***
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bfp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    // all state in one record
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } bfp_fifo_state_type;
    bfp_fifo_state_type st; // current state
    bfp_fifo_state_type next_st; // next state
    logic push; // word written
    logic pop; // word read
    assign in_ready = (st.count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = st.wptr + AW'(1);
        end
        if (pop) begin
            next_st.rptr = st.rptr + AW'(1);
        end
        if (push && !pop) begin
            next_st.count = st.count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_st.count = st.count - (AW+1)'(1);
        end
    end
    // register the record
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** verilog/bfp_host.sv ***
// programming controller end: sends byte strings, collects replies
`timescale 1ns/1ps
`include "bfp_consts.svh"
module bfp_host
    import bfp_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    bfp_link_if.host link,
    input wire logic [7:0] tx_data, // byte to send; user forms checksums
    input wire logic tx_err, // mark byte as received in error
    input wire logic tx_valid, // user offers a byte
    output logic tx_ready, // byte taken
    output logic [7:0] rx_data, // last reply byte
    output logic rx_strobe // pulse: new reply in rx_data
);
    // ************************************************
    // state record
    // ************************************************
    typedef struct packed {
        bfp_host_state_type phase;
        logic [7:0] data;
        logic err;
        logic [7:0] rdata;
        logic rstb;
    } bfp_host_rec_type;
    bfp_host_rec_type st; // current
    bfp_host_rec_type next_st; // next
    assign link.h2d_data = st.data;
    assign link.h2d_err = st.err;
    assign link.h2d_valid = (st.phase == BFP_HOST_SEND);
    assign link.d2h_ready = 1'b1;
    assign tx_ready = (st.phase == BFP_HOST_IDLE);
    assign rx_data = st.rdata;
    assign rx_strobe = st.rstb;
    // ordering of the byte string is left to the user
    always_comb begin
        next_st = st;
        next_st.rstb = 1'b0;
        unique case (st.phase)
            BFP_HOST_IDLE: begin
                if (tx_valid) begin
                    next_st.data = tx_data;
                    next_st.err = tx_err;
                    next_st.phase = BFP_HOST_SEND;
                end
            end
            BFP_HOST_SEND: begin
                if (link.h2d_ready) begin
                    next_st.phase = BFP_HOST_IDLE;
                end
            end
            default: begin
                next_st.phase = BFP_HOST_IDLE;
            end
        endcase
        if (link.d2h_valid) begin
            next_st.rdata = link.d2h_data;
            next_st.rstb = 1'b1;
        end
    end
    // register the record
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** sim/bfp_link_chk.sv ***
// link assertions between the controller and the boot interpreter
`timescale 1ns/1ps
module bfp_link_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_valid,
    input wire logic h2d_err,
    input wire logic h2d_ready,
    input wire logic [7:0] d2h_data,
    input wire logic d2h_valid,
    input wire logic d2h_ready
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // ****************
    // helper logic
    // ****************
    logic h2d_take; // byte taken by the device
    logic d2h_take; // reply taken by the controller
    logic [7:0] last_rep; // reply taken before this one
    assign h2d_take = h2d_valid && h2d_ready;
    assign d2h_take = d2h_valid && d2h_ready;
    // remember the previous reply byte
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_rep <= 8'h00;
        end else if (d2h_take) begin
            last_rep <= d2h_data;
        end
    end
    // ****************
    // assertions
    // ****************
    AST_H2D_HOLD: assert property (h2d_valid && !h2d_ready |=>
        h2d_valid && $stable(h2d_data) && $stable(h2d_err)) else $error("byte dropped");
    AST_H2D_GAP: assert property (h2d_take |=> !h2d_take) else $error("bytes too close");
    AST_REPLY_NIB: assert property (d2h_valid |-> d2h_data[3:0] inside
        {4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'hc, 4'hd, 4'hf}) else $error("bad reply code");
    AST_ERASE_OK: assert property (d2h_take && d2h_data == 8'h4f |->
        ##[1:4] (d2h_take && d2h_data == 8'h5d)) else $error("no completion ack");
    AST_ERASE_BAD: assert property (d2h_take && d2h_data == 8'h4c |->
        ##[1:4] (d2h_take && d2h_data == 8'h60)) else $error("no error ack");
    AST_ERASE_RES: assert property (d2h_take && d2h_data inside {8'h4f, 8'h4c} |->
        last_rep == 8'h54) else $error("erase result without enable echo");
    AST_ERASE_HOLD: assert property (d2h_take && d2h_data == 8'h54 |->
        !h2d_ready [*4]) else $error("byte taken while erasing");
    AST_CMD_AFTER: assert property (d2h_take && d2h_data == 8'h5d |->
        ##[0:3] h2d_ready) else $error("no command wait after erase");
endmodule

// *** sim/testbench.sv ***
// self-checking bench: controller and boot interpreter joined over the byte link
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module testbench
    import bfp_pkg::*;
;
    logic core_clk, arst_n, tx_err, tx_valid, tx_ready, rx_strobe; // user side
    logic [7:0] tx_data, rx_data, flash_wdata, flash_rdata;
    logic read_protect, write_protect, erase_start, erase_done, erase_fail; // flash side
    logic flash_we, pwd_done, pwd_ok, pwd_res;
    logic [31:0] flash_addr;
    int n_errors = 0, check_count = 0, cyc = 0, ecnt = 0, pwd_seen = 0;
    logic [7:0] rq[$]; // replies seen by the controller
    logic [31:0] wa[$]; // programmed addresses
    logic [7:0] wd[$]; // programmed bytes
    logic [7:0] pwd_mem[16]; // password area contents
    bfp_link_if link ();
    bfp_host i_bfp_host (.core_clk(core_clk), .arst_n(arst_n), .link(link), .tx_data(tx_data),
        .tx_err(tx_err), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_strobe(rx_strobe));
    bfp_device i_bfp_device (.core_clk(core_clk), .arst_n(arst_n), .link(link),
        .read_protect(read_protect), .write_protect(write_protect), .erase_start(erase_start),
        .erase_done(erase_done), .erase_fail(erase_fail), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_we(flash_we), .flash_rdata(flash_rdata),
        .pwd_done(pwd_done), .pwd_ok(pwd_ok));
    bfp_link_chk i_bfp_link_chk (.core_clk(core_clk), .arst_n(arst_n),
        .h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid), .h2d_err(link.h2d_err),
        .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid),
        .d2h_ready(link.d2h_ready));
    // password area read, anything else reads as erased
    assign flash_rdata = (flash_addr[31:4] == 28'h0004fef) ?
        pwd_mem[4'(flash_addr[3:0] - 4'h4)] : 8'hff;
    // ****************
    // clock, monitors, erase stand-in
    // ****************
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // collect replies, writes and password results; cut a hang short
    always @(posedge core_clk) begin
        cyc++;
        if (rx_strobe === 1'b1) rq.push_back(rx_data);
        if (flash_we === 1'b1) begin
            wa.push_back(flash_addr);
            wd.push_back(flash_wdata);
        end
        if (pwd_done === 1'b1) begin
            pwd_seen++;
            pwd_res = pwd_ok;
        end
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end
    // erase finishes ten cycles after its start pulse
    always @(posedge core_clk) begin
        erase_done <= 1'b0;
        if (erase_start === 1'b1) ecnt <= 10;
        else if (ecnt == 1) begin
            erase_done <= 1'b1;
            ecnt <= 0;
        end else if (ecnt != 0) ecnt <= ecnt - 1;
    end
    // ****************
    // shared tasks
    // ****************
    task automatic send(input logic [7:0] b, input logic e);
        int n = 0;
        tx_data = b;
        tx_err = e;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 300) n_errors++;
        @(posedge core_clk);
        #1;
        tx_valid = 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic rep(input logic [7:0] e);
        int n = 0;
        logic [7:0] g;
        while (rq.size() == 0 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        g = (rq.size() == 0) ? 8'hxx : rq.pop_front();
        `CHK(g, e)
    endtask
    // one program exchange; herr/derr pick an errored byte, adj spoils a checksum
    task automatic prog(input logic [31:0] a, input logic [15:0] c, input int herr,
        input logic [7:0] hadj, input int derr, input logic [7:0] dadj,
        input logic [7:0] hrep, input logic [7:0] drep);
        logic [7:0] h[7];
        logic [7:0] s = 8'h00;
        h = '{a[31:24], a[23:16], a[15:8], a[7:0], c[15:8], c[7:0], 8'h00};
        for (int i = 0; i < 6; i++) s = s + h[i];
        h[6] = hadj - s;
        send(8'h50, 1'b0);
        rep(8'h50);
        for (int i = 0; i < 7; i++) send(h[i], i == herr);
        rep(hrep);
        if (hrep != 8'h50) return;
        s = 8'h00;
        for (int i = 0; i < c; i++) begin
            send(8'ha0 + i[7:0], i == derr);
            s = s + 8'ha0 + i[7:0];
        end
        send(dadj - s, 1'b0);
        rep(drep);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_cmd();
        send(8'h50, 1'b0);
        rep(8'h04);
        send(8'h40, 1'b1);
        rep(8'h58);
        send(8'h7f, 1'b0);
        rep(8'h51);
        for (int i = 1; i < 4; i++) begin
            send({i[3:0], 4'h0}, 1'b0);
            rep({i[3:0], 4'h0});
        end
    endtask
    task automatic erase_try(input logic [7:0] en, input logic e, input logic [7:0] r);
        send(8'h40, 1'b0);
        rep(8'h40);
        send(en, e);
        rep(r);
    endtask
    task automatic t_erase();
        erase_try(8'h54, 1'b1, 8'h48);
        erase_try(8'h33, 1'b0, 8'h41);
        erase_fail = 1'b1;
        erase_try(8'h54, 1'b0, 8'h54);
        rep(8'h4c);
        rep(8'h60);
        send(8'h50, 1'b0);
        rep(8'h44);
        erase_fail = 1'b0;
        erase_try(8'h54, 1'b0, 8'h54);
        send(8'h20, 1'b0);
        rep(8'h4f);
        rep(8'h5d);
        rep(8'h20);
        for (int i = 0; i < 2; i++) begin
            read_protect = (i == 0);
            write_protect = (i == 1);
            send(8'h50, 1'b0);
            rep(i == 0 ? 8'h26 : 8'h56);
        end
        read_protect = 1'b0;
        write_protect = 1'b0;
    endtask
    task automatic t_prog();
        prog(32'h00010000, 16'h0003, -1, 8'h00, -1, 8'h00, 8'h50, 8'h50);
        `CHK(wa.size(), 3)
        for (int i = 0; i < 3; i++) begin
            `CHK(wa[i], 32'h00010000 + i)
            `CHK(wd[i], 8'ha0 + i[7:0])
        end
        prog(32'h0004fffe, 16'h0001, 2, 8'h00, -1, 8'h00, 8'h58, 8'h00);
        prog(32'h00010100, 16'h0001, -1, 8'h01, -1, 8'h00, 8'h51, 8'h00);
        prog(32'h00010200, 16'h0002, -1, 8'h00, 1, 8'h00, 8'h50, 8'h58);
        prog(32'h00010300, 16'h0002, -1, 8'h00, -1, 8'h01, 8'h50, 8'h51);
        wa.delete();
        prog(32'h00020000, 16'h0400, -1, 8'h00, -1, 8'h00, 8'h50, 8'h50);
        `CHK(wa.size(), 1024)
        `CHK(wa[1023], 32'h000203ff)
    endtask
    task automatic t_pwd();
        int n;
        for (int k = 0; k < 2; k++) begin
            pwd_seen = 0;
            n = 0;
            send(8'h60, 1'b0);
            rep(8'h60);
            for (int i = 0; i < 12; i++) send(pwd_mem[i] ^ {7'h00, k == 1 && i == 11}, 1'b0);
            while (pwd_seen == 0 && n < 20) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            `CHK(pwd_seen, 1)
            `CHK(pwd_res, k == 0)
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // main sequence: reset for sixteen cycles, then each scenario in turn
    initial begin
        arst_n = 1'b0;
        tx_data = 8'h00;
        tx_err = 1'b0;
        tx_valid = 1'b0;
        read_protect = 1'b0;
        write_protect = 1'b0;
        erase_fail = 1'b0;
        for (int i = 0; i < 16; i++) pwd_mem[i] = 8'h5a ^ i[7:0];
        repeat (16) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        t_cmd();
        t_erase();
        t_prog();
        t_pwd();
        `CHK(rq.size(), 0)
        test_done();
    end
endmodule
